// [eeprom_link_params.svh]
`ifndef EEPROM_LINK_PARAMS_SVH
`define EEPROM_LINK_PARAMS_SVH

// Control code that selects the memory device
`define CTRL_CODE 4'hA
`define ADDR_W 13
`define ADDR_RESET 13'h0000
// Position of the direction bit in the control byte
`define CTRL_RW_BIT 0

`define CORE_CLK_NS 4
`define LINK_CLK_NS 12

// Quarter of one serial clock period, made by the master
`define SCL_QTR_NS 100
`define SCL_QTR_CLKS ((`SCL_QTR_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)

// Length of the self-timed write cycle
`define WRITE_CYCLE_NS 20000
`define WRITE_CYCLE_CLKS ((`WRITE_CYCLE_NS + `LINK_CLK_NS - 1) / `LINK_CLK_NS)

`define RD_FIFO_WIDTH 8
`define RD_FIFO_DEPTH 8

`endif

// [eeprom_link_pkg.sv]
`default_nettype none

package eeprom_link_pkg;

  typedef logic [12:0] word_addr_type;

  typedef enum logic [2:0] {DEV_IDLE, DEV_RX, DEV_ACK_OUT, DEV_TX, DEV_ACK_IN} dev_state_type;

  typedef enum logic [1:0] {BYTE_CTRL, BYTE_ADDR_HI, BYTE_ADDR_LO, BYTE_DATA} byte_kind_type;

  typedef enum logic [2:0] {H_IDLE, H_START, H_TX, H_RX, H_STOP} host_state_type;

  typedef enum logic [2:0] {
    P_CTRL_W, P_ADDR_HI, P_ADDR_LO, P_WDATA, P_POLL, P_CTRL_R, P_RDATA, P_DONE
  } host_phase_type;

endpackage

`default_nettype wire

// [eeprom_link_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface eeprom_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;

  // Open-drain data line with pull-up
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport master (output scl, output host_sda_o, output host_sda_oe_n, input sda);
  modport target (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface

`default_nettype wire

// [eeprom_fifo.sv]
`timescale 1ns/10ps
`default_nettype none

module eeprom_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // DEPTH must be a power of two so the pointers wrap by themselves
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] CNT_FULL = (PW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } fifo_reg_type;

  fifo_reg_type q;
  fifo_reg_type d;
  logic push;
  logic pop;

  assign in_ready = (q.cnt != CNT_FULL);
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wp] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (pop)
      d.rp = q.rp + 1'b1;
    if (push && !pop)
      d.cnt = q.cnt + 1'b1;
    else if (pop && !push)
      d.cnt = q.cnt - 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end
endmodule

`default_nettype wire

// [eeprom_master.sv]
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_link_params.svh"

module eeprom_master (
  input wire logic core_clk,
  input wire logic rst_n,
  eeprom_link_if.master link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic cmd_random,
  input wire logic [2:0] cmd_cs,
  input wire eeprom_link_pkg::word_addr_type cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_len,
  output logic done,
  output logic nack_err,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data
);
  import eeprom_link_pkg::*;

  localparam logic [7:0] QTR_LAST = 8'(`SCL_QTR_CLKS - 1);

  typedef struct packed {
    logic sda_m;
    logic sda_s;
    host_state_type st;
    host_phase_type ph;
    logic [1:0] qt;
    logic [7:0] tk;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic samp;
    logic scl;
    logic sda;
    logic read;
    logic random;
    logic [2:0] cs;
    word_addr_type addr;
    logic [7:0] wdata;
    logic [7:0] len;
    logic push;
    logic [7:0] pdata;
    logic done;
    logic err;
  } host_reg_type;

  host_reg_type q;
  host_reg_type d;
  logic fifo_in_ready;
  logic hold;

  // Level of the data line during the current bit
  function automatic logic bit_level(input host_state_type st, input logic [3:0] cnt,
                                     input logic [7:0] sh, input logic [7:0] len);
    if (st == H_TX)
      return (cnt < 4'd8) ? sh[7] : 1'b1;
    return (cnt < 4'd8) ? 1'b1 : (len <= 8'h01); // R12 R13
  endfunction

  function automatic logic [7:0] ctrl_byte(input logic [2:0] cs, input logic rd);
    return {`CTRL_CODE, cs, rd};
  endfunction

  assign cmd_ready = (q.st == H_IDLE);
  assign done = q.done;
  assign nack_err = q.err;
  assign link.scl = q.scl;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe_n = q.sda;
  assign hold = (q.st == H_RX) && (q.cnt == 4'd0) && (q.qt == 2'd0) && !fifo_in_ready;

  always_comb
  begin
    d = q;
    d.sda_m = link.sda;
    d.sda_s = q.sda_m;
    d.push = 1'b0;
    d.done = 1'b0;
    if (q.st == H_IDLE)
    begin
      if (cmd_valid)
      begin
        d.read = cmd_read;
        d.random = cmd_random;
        d.cs = cmd_cs;
        d.addr = cmd_addr;
        d.wdata = cmd_wdata;
        d.len = cmd_len;
        d.err = 1'b0;
        d.st = H_START;
        d.qt = 2'd0;
        d.tk = '0;
        d.ph = (cmd_read && !cmd_random) ? P_CTRL_R : P_CTRL_W; // R5
      end
    end
    else if (hold || q.tk != QTR_LAST)
      d.tk = hold ? '0 : q.tk + 1'b1;
    else
    begin
      d.tk = '0;
      d.qt = q.qt + 1'b1;
      if (q.qt == 2'd2)
        d.samp = q.sda_s;
      if (q.qt == 2'd3)
      begin
        d.cnt = q.cnt + 1'b1;
        case (q.st)
          H_START:
          begin
            d.st = H_TX;
            d.cnt = '0;
            d.sh = ctrl_byte(q.cs, q.ph == P_CTRL_R); // R3
          end
          H_TX:
          begin
            if (q.cnt < 4'd8)
              d.sh = {q.sh[6:0], 1'b0};
            else
            begin
              d.cnt = '0;
              if (q.samp)
              begin
                d.st = (q.ph == P_POLL) ? H_START : H_STOP; // R3
                d.err = (q.ph != P_POLL);
              end
              else
                case (q.ph)
                  P_CTRL_W:
                  begin
                    d.ph = P_ADDR_HI;
                    d.sh = {3'h0, q.addr[12:8]};
                  end
                  P_ADDR_HI:
                  begin
                    d.ph = P_ADDR_LO;
                    d.sh = q.addr[7:0];
                  end
                  P_ADDR_LO:
                  begin
                    d.ph = q.read ? P_CTRL_R : P_WDATA;
                    d.st = q.read ? H_START : H_TX; // R8
                    d.sh = q.wdata;
                  end
                  P_WDATA:
                  begin
                    d.ph = P_POLL;
                    d.st = H_STOP; // R2
                  end
                  P_POLL:
                  begin
                    d.ph = P_DONE;
                    d.st = H_STOP; // R4
                  end
                  P_CTRL_R:
                  begin
                    d.ph = P_RDATA;
                    d.st = H_RX;
                  end
                  default:
                    d.st = H_STOP;
                endcase
            end
          end
          H_RX:
          begin
            if (q.cnt < 4'd8)
              d.sh = {q.sh[6:0], q.samp};
            else
            begin
              d.cnt = '0;
              d.push = 1'b1;
              d.pdata = q.sh;
              d.len = q.len - 1'b1;
              d.st = (q.len <= 8'h01) ? H_STOP : H_RX; // R13
            end
          end
          H_STOP:
          begin
            d.cnt = '0;
            d.st = (q.ph == P_POLL) ? H_START : H_IDLE; // R2
            d.done = (q.ph != P_POLL);
          end
          default:
            d.st = H_IDLE;
        endcase
      end
    end
    // Line levels for the quarter that starts next
    case (d.st)
      H_START:
      begin
        d.scl = (d.qt == 2'd1) || (d.qt == 2'd2);
        d.sda = (d.qt < 2'd2);
      end
      H_STOP:
      begin
        d.scl = (d.qt != 2'd0);
        d.sda = (d.qt >= 2'd2);
      end
      H_TX, H_RX:
      begin
        d.scl = (d.qt == 2'd1) || (d.qt == 2'd2);
        d.sda = bit_level(d.st, d.cnt, d.sh, d.len);
      end
      default:
      begin
        d.scl = 1'b1;
        d.sda = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.scl <= 1'b1;
      q.sda <= 1'b1;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
    end
    else
      q <= d;
  end

  eeprom_fifo #(
    .WIDTH(`RD_FIFO_WIDTH),
    .DEPTH(`RD_FIFO_DEPTH)
  ) u_rd_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .in_valid(q.push),
    .in_ready(fifo_in_ready),
    .in_data(q.pdata),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );
endmodule

`default_nettype wire

// [eeprom_target.sv]
// Functional notes
// [R1] Busy write cycle: never ack control byte
// [R2] Write cycle starts at Stop; poll immediately
// [R3] Master repeats Start and control on no-ack; code repeats only while polling, otherwise it sends Stop and sets nack_err
// [R4] Ack polling once done; master continues
// [R5] Direction bit one selects read forms
// [R6] Pointer holds last accessed plus one
// [R7] Read control: ack, send byte, stop ends
// [R8] Random read: address write, then new Start
// [R9] Repeated Start drops write, keeps address
// [R10] Read control after restart returns addressed byte
// [R11] After random read pointer is next location
// [R12] Master ack requests next sequential byte
// [R13] Last byte: master no-ack then Stop
// [R14] Pointer increments after every byte
// [R15] Pointer wraps from top to zero
// [R16] Control code and chip selects must match
// [R17] Address high byte first, thirteen bits used
// [R18] Master no-ack: release data line high
// [R19] Mismatch: stay idle until next Start
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_link_params.svh"

module eeprom_target (
  input wire logic link_clk,
  input wire logic rst_n,
  eeprom_link_if.target link,
  input wire logic chip_select_in_2,
  input wire logic chip_select_in_1,
  input wire logic chip_select_in_0,
  output eeprom_link_pkg::word_addr_type mem_addr,
  input wire logic [7:0] mem_rdata,
  output logic mem_we,
  output eeprom_link_pkg::word_addr_type mem_waddr,
  output logic [7:0] mem_wdata,
  output logic write_busy
);
  import eeprom_link_pkg::*;

  localparam logic [15:0] WRITE_CLKS = 16'(`WRITE_CYCLE_CLKS);

  typedef struct packed {
    logic [4:0] meta;
    logic [4:0] sync;
    logic scl_p;
    logic sda_p;
    dev_state_type st;
    byte_kind_type kind;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic drive_low;
    word_addr_type addr;
    word_addr_type waddr;
    logic [7:0] wdata;
    logic pend;
    logic we;
    logic [15:0] busy;
  } dev_reg_type;

  dev_reg_type q;
  dev_reg_type d;
  logic scl_s;
  logic sda_s;
  logic [2:0] cs_s;
  logic rise;
  logic fall;
  logic start_seen;
  logic stop_seen;

  function automatic logic ctrl_match(input logic [7:0] b, input logic [2:0] cs);
    return (b[7:4] == `CTRL_CODE) && (b[3:1] == cs);
  endfunction

  // Thirteen-bit sum wraps from the top location to zero
  function automatic word_addr_type next_addr(input word_addr_type a);
    return a + 1'b1;
  endfunction

  assign scl_s = q.sync[4];
  assign sda_s = q.sync[3];
  assign cs_s = q.sync[2:0];
  assign rise = scl_s & ~q.scl_p;
  assign fall = ~scl_s & q.scl_p;
  assign start_seen = scl_s & q.scl_p & q.sda_p & ~sda_s;
  assign stop_seen = scl_s & q.scl_p & ~q.sda_p & sda_s;

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe_n = ~q.drive_low;
  assign mem_addr = q.addr;
  assign mem_we = q.we;
  assign mem_waddr = q.waddr;
  assign mem_wdata = q.wdata;
  assign write_busy = (q.busy != '0);

  always_comb
  begin
    d = q;
    d.meta = {link.scl, link.sda, chip_select_in_2, chip_select_in_1, chip_select_in_0};
    d.sync = q.meta;
    d.scl_p = scl_s;
    d.sda_p = sda_s;
    d.we = 1'b0;
    if (q.busy != '0)
      d.busy = q.busy - 1'b1;
    if (stop_seen)
    begin
      d.st = DEV_IDLE;
      d.drive_low = 1'b0;
      if (q.pend)
      begin
        d.pend = 1'b0;
        d.we = 1'b1;
        d.busy = WRITE_CLKS; // R2
      end
    end
    else if (start_seen)
    begin
      d.st = DEV_RX;
      d.kind = BYTE_CTRL;
      d.cnt = '0;
      d.drive_low = 1'b0;
      d.pend = 1'b0; // R9
    end
    else
      case (q.st)
        DEV_RX:
        begin
          if (rise)
          begin
            d.sh = {q.sh[6:0], sda_s};
            d.cnt = q.cnt + 1'b1;
          end
          else if (fall && q.cnt == 4'd8)
          begin
            d.st = DEV_ACK_OUT;
            d.drive_low = 1'b1;
            case (q.kind)
              BYTE_CTRL:
              begin
                d.rw = q.sh[`CTRL_RW_BIT]; // R5
                d.kind = BYTE_ADDR_HI;
                if (!ctrl_match(q.sh, cs_s) || q.busy != '0) // R16 R1 R4
                begin
                  d.st = DEV_IDLE; // R1 R19
                  d.drive_low = 1'b0;
                end
              end
              BYTE_ADDR_HI:
              begin
                d.addr[12:8] = q.sh[4:0]; // R17
                d.kind = BYTE_ADDR_LO;
              end
              BYTE_ADDR_LO:
              begin
                d.addr[7:0] = q.sh; // R9
                d.kind = BYTE_DATA;
              end
              default:
              begin
                d.wdata = q.sh;
                d.waddr = q.addr;
                d.pend = 1'b1;
                d.addr = next_addr(q.addr); // R14
              end
            endcase
          end
        end
        DEV_ACK_OUT:
        begin
          if (fall)
          begin
            d.cnt = '0;
            d.drive_low = 1'b0;
            d.st = DEV_RX;
            if (q.rw)
            begin
              d.st = DEV_TX; // R7 R10
              d.sh = mem_rdata;
              d.cnt = 4'd1;
              d.drive_low = ~mem_rdata[7];
              d.addr = next_addr(q.addr); // R6 R11
            end
          end
        end
        DEV_TX:
        begin
          if (fall)
          begin
            if (q.cnt == 4'd8)
            begin
              d.drive_low = 1'b0;
              d.st = DEV_ACK_IN;
            end
            else
            begin
              d.sh = {q.sh[6:0], 1'b0};
              d.drive_low = ~q.sh[6];
              d.cnt = q.cnt + 1'b1;
            end
          end
        end
        DEV_ACK_IN:
        begin
          if (rise)
          begin
            if (sda_s)
              d.st = DEV_IDLE; // R18
            else
              d.cnt = 4'd9;
          end
          else if (fall && q.cnt == 4'd9)
          begin
            d.st = DEV_TX; // R12
            d.sh = mem_rdata;
            d.cnt = 4'd1;
            d.drive_low = ~mem_rdata[7];
            d.addr = next_addr(q.addr); // R14 R15
          end
        end
        default:
          d.drive_low = 1'b0; // R19
      endcase
  end

  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.meta <= 5'h18;
      q.sync <= 5'h18;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.addr <= `ADDR_RESET;
    end
    else
      q <= d;
  end
endmodule

`default_nettype wire

// [eeprom_link_props.sv]
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_link_params.svh"

module eeprom_link_props (
  input wire logic core_clk,
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic write_busy,
  input wire logic mem_we
);
  localparam logic [15:0] BUSY_LEN = 16'(`WRITE_CYCLE_CLKS);

  // Length of the current run of busy cycles
  logic [15:0] busy_run_q;

  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_run_q <= '0;
    else if (write_busy)
      busy_run_q <= busy_run_q + 1'b1;
    else
      busy_run_q <= '0;
  end

  sequence busy_hold_s;
    write_busy[*8];
  endsequence
  sequence busy_over_s;
    busy_run_q == BUSY_LEN;
  endsequence

  open_drain_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    dev_sda_o == 1'b0) else $error("target drives data line high");
  busy_quiet_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    write_busy |-> dev_sda_oe_n) else $error("target pulls line while busy");
  commit_busy_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    mem_we |-> ##[0:2] write_busy) else $error("no write cycle after commit");
  commit_once_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    mem_we |-> !$past(write_busy) ##1 !mem_we) else $error("commit while busy or repeated");
  busy_len_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    $rose(write_busy) |-> busy_hold_s) else $error("write cycle too short");
  busy_end_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    $fell(write_busy) |-> busy_over_s) else $error("write cycle length wrong");
  drive_low_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    $changed(dev_sda_oe_n) |-> !scl) else $error("target changes line while clock high");
  ack_steady_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    scl && $past(scl) |-> $stable(dev_sda_oe_n)) else $error("target line unstable");
  start_owner_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(sda) && scl && $past(scl) |-> !host_sda_oe_n) else $error("false start");
  stop_release_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(sda) && scl && $past(scl) |-> dev_sda_oe_n) else $error("stop while held");
endmodule

`default_nettype wire

// [eeprom_read_and_ack_polling_test.sv]
`timescale 1ns/10ps
`default_nettype none

module eeprom_read_and_ack_polling_test;
  import eeprom_link_pkg::*;

  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_random = 1'b0;
  logic [2:0] cmd_cs = 3'h0;
  word_addr_type cmd_addr = 13'h0000;
  logic [7:0] cmd_wdata = 8'h00;
  logic [7:0] cmd_len = 8'h00;
  logic rd_ready = 1'b0;
  logic [2:0] cs_strap = 3'h5;
  logic cmd_ready;
  logic done;
  logic nack_err;
  logic rd_valid;
  logic [7:0] rd_data;
  word_addr_type mem_addr;
  word_addr_type mem_waddr;
  logic [7:0] mem_wdata;
  logic mem_we;
  logic write_busy;
  logic [7:0] mem [8192];
  int ref_mem [8192];
  int ref_ptr = 0;
  int we_seen = 0;
  int we_want = 0;
  int err_total = 0;
  int checked = 0;
  int seed = 32'h5B27;
  time stall_end = 0;
  logic [7:0] got [$];

  always #2 core_clk = ~core_clk;
  initial
  begin
    #1.5;
    forever #6 link_clk = ~link_clk;
  end

  eeprom_link_if u_eeprom_link_if ();

  eeprom_master u_eeprom_master (.core_clk(core_clk), .rst_n(rst_n), .link(u_eeprom_link_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_random(cmd_random), .cmd_cs(cmd_cs), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_len(cmd_len), .done(done), .nack_err(nack_err), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data));

  eeprom_target u_eeprom_target (.link_clk(link_clk), .rst_n(rst_n), .link(u_eeprom_link_if),
    .chip_select_in_2(cs_strap[2]), .chip_select_in_1(cs_strap[1]),
    .chip_select_in_0(cs_strap[0]), .mem_addr(mem_addr), .mem_rdata(mem[mem_addr]),
    .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .write_busy(write_busy));

  eeprom_link_props u_eeprom_link_props (.core_clk(core_clk), .link_clk(link_clk),
    .rst_n(rst_n), .scl(u_eeprom_link_if.scl), .sda(u_eeprom_link_if.sda),
    .host_sda_oe_n(u_eeprom_link_if.host_sda_oe_n), .dev_sda_o(u_eeprom_link_if.dev_sda_o),
    .dev_sda_oe_n(u_eeprom_link_if.dev_sda_oe_n), .write_busy(write_busy), .mem_we(mem_we));

  // Storage array behind the target
  always @(posedge link_clk)
    if (mem_we === 1'b1)
    begin
      mem[mem_waddr] <= mem_wdata;
      we_seen <= we_seen + 1;
    end

  // Ready held low until stall_end lets the read FIFO fill and stall the link, then sparse
  always @(posedge core_clk)
    #1 rd_ready = ($time >= stall_end) && (($random(seed) & 3) == 0);

  always @(posedge core_clk)
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
      got.push_back(rd_data);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", what, want, seen);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic run_cmd(input logic rd, input logic rnd, input logic [2:0] cs, input int a,
                         input int wd, input int ln);
    int w;
    int n;
    got.delete();
    cmd_read = rd;
    cmd_random = rnd;
    cmd_cs = cs;
    cmd_addr = a[12:0];
    cmd_wdata = wd[7:0];
    cmd_len = ln[7:0];
    cmd_valid = 1'b1;
    w = 0;
    while (cmd_ready !== 1'b1 && w < 50)
    begin
      w++;
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    #1 cmd_valid = 1'b0;
    if (w >= 50)
      w = 40000;
    else
      w = 0;
    while (done !== 1'b1 && w < 40000)
    begin
      w++;
      @(posedge core_clk);
      #1;
    end
    n = 0;
    while (rd_valid === 1'b1 && n < 200)
    begin
      n++;
      @(posedge core_clk);
      #1;
    end
    if (w >= 40000 || n >= 200)
    begin
      err_total++;
      final_report();
    end
    if (cs != cs_strap)
    begin
      check("nack", nack_err, 1);
      check("bytes", got.size(), 0);
    end
    else if (rd)
    begin
      if (rnd)
        ref_ptr = a;
      n = (ln == 0) ? 1 : ln;
      check("bytes", got.size(), n);
      for (int i = 0; i < got.size(); i++)
      begin
        check("rdata", got[i], ref_mem[ref_ptr]);
        ref_ptr = (ref_ptr + 1) % 8192;
      end
      check("nack", nack_err, 0);
    end
    else
    begin
      ref_mem[a] = wd;
      ref_ptr = (a + 1) % 8192;
      we_want++;
      check("nack", nack_err, 0);
    end
    check("commits", we_seen, we_want);
  endtask

  initial
  begin
    for (int i = 0; i < 8192; i++)
    begin
      mem[i] = 8'($random(seed));
      ref_mem[i] = mem[i];
    end
    repeat (8) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (30) @(posedge core_clk);
    #1;
    run_cmd(1, 0, cs_strap, 0, 0, 2);
    // Back-to-back writes: each one polls through its own busy cycle before done
    run_cmd(0, 0, cs_strap, 13'h0123, 8'h5A, 1);
    run_cmd(0, 0, cs_strap, 13'h1FFF, 8'hC3, 1);
    run_cmd(1, 0, cs_strap, 0, 0, 1);
    run_cmd(1, 1, cs_strap, 13'h0123, 0, 1);
    run_cmd(1, 0, cs_strap, 0, 0, 1);
    // Ready held off so the read FIFO fills and the link waits
    stall_end = $time + 60000;
    run_cmd(1, 1, cs_strap, 13'h1FFD, 0, 10);
    for (int c = 0; c < 8; c++)
      run_cmd(1, 0, c[2:0], 0, 0, 1);
    for (int k = 0; k < 5; k++)
      run_cmd(1'($random(seed)), 1'($random(seed)), cs_strap, $random(seed) & 8191,
              $random(seed) & 255, $random(seed) & 3);
    final_report();
  end
endmodule

`default_nettype wire
